/* hdl/spm_pkg.sv */
// Shared constants and types for the servo parameter store and mode selector
package spm_pkg;
	localparam int          NPAR      = 16;
	localparam int          DW        = 16;
	localparam int          AW        = 12;
	// Register byte addresses and the block decode mask
	localparam logic [11:0] ADDR_STATUS       = 12'h000;
	localparam logic [11:0] ADDR_REJECT       = 12'h004;
	localparam logic [11:0] ADDR_ACTIVE_BASE  = 12'h040;
	localparam logic [11:0] ADDR_PENDING_BASE = 12'h080;
	localparam logic [11:0] ADDR_BLOCK_MASK   = 12'hFC0;
	// Parameter indices
	localparam logic [3:0]  IDX_EXPANSION = 4'h0;
	localparam logic [3:0]  IDX_FORCE_OFF = 4'h1;
	localparam logic [3:0]  IDX_MODE      = 4'h2;
	localparam logic [3:0]  IDX_SPEED1    = 4'h5;
	localparam logic [3:0]  IDX_POS0      = 4'h8;
	// Per-parameter attribute masks, bit i belongs to parameter i; then reset, force-off and analog values
	localparam logic [15:0] PWRCYC_MASK   = 16'h0005;
	localparam logic [15:0] VOLATILE_MASK = 16'h0010;
	localparam logic [15:0] LOCKED_MASK   = 16'h0008;
	localparam logic [15:0] EXPGRP_MASK   = 16'h00E0;
	localparam logic [15:0] PARAM_RESET   = 16'h0000;
	localparam logic [15:0] FORCE_OFF_ON  = 16'h0001;
	localparam logic [15:0] ANALOG_VALUE  = 16'h0000;
	// Control-mode setting codes (low nibble of the mode parameter)
	localparam logic [3:0]  MC_PT    = 4'h0;
	localparam logic [3:0]  MC_PR    = 4'h1;
	localparam logic [3:0]  MC_SPEED = 4'h2;
	localparam logic [3:0]  MC_TORQ  = 4'h3;
	localparam logic [3:0]  MC_PT_S  = 4'h4;
	localparam logic [3:0]  MC_PT_T  = 4'h5;
	localparam logic [3:0]  MC_PR_S  = 4'h6;
	localparam logic [3:0]  MC_PR_T  = 4'h7;
	localparam logic [3:0]  MC_S_T   = 4'h8;
	// Reject register bits
	localparam int          REJ_LOCK = 0;
	localparam int          REJ_EXP  = 1;

	typedef enum logic [1:0] {BM_PT, BM_PR, BM_SPEED, BM_TORQUE} spm_mode_t;
	typedef enum logic [1:0] {SRC_PULSE, SRC_INTPOS, SRC_ANALOG, SRC_SPEEDREG} spm_src_t;

	typedef struct packed {
		logic       servoOnInput;
		logic       modeToggleInput;
		logic       speedSelectLow;
		logic       speedSelectHigh;
		logic [2:0] positionSelect;
		logic       powerCycle;
		logic       pulseStep;
		logic       pulseDir;
	} spm_pins_t;

	typedef struct packed {
		logic              servoActive;
		spm_mode_t         activeMode;
		spm_src_t          cmdSource;
		logic [DW-1:0]     cmdValue;
		logic [DW-1:0]     goalPosition;
	} spm_drive_t;
endpackage

/* hdl/spm_store.sv */
// Servo parameter store with control-mode selection, APB register access
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module spm_store (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [spm_pkg::AW-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic      [31:0]           prdata,
	output logic                       pslverr,
	input  wire spm_pkg::spm_pins_t    pins,
	output spm_pkg::spm_drive_t        drive
);
	typedef struct packed {
		spm_pkg::spm_pins_t                       sync1;
		spm_pkg::spm_pins_t                       sync2;
		logic                                     stepPrev;
		logic                                     cyclePrev;
		logic [spm_pkg::NPAR-1:0][spm_pkg::DW-1:0] active;
		logic [spm_pkg::NPAR-1:0][spm_pkg::DW-1:0] pending;
		logic [1:0]                               reject;
		logic                                     pready;
		logic [31:0]                              prdata;
		logic                                     pslverr;
		spm_pkg::spm_drive_t                      drive;
	} spm_state_t;

	spm_state_t state;
	spm_state_t next_state;

	logic              access;
	logic              hitActive;
	logic              hitPending;
	logic [3:0]        idx;
	logic              expansionOpen;
	logic              lockHit;
	logic              expHit;
	logic              stepRise;
	logic              cycleRise;
	logic [3:0]        modeCode;
	logic [1:0]        speedCode;
	logic [3:0]        speedIdx;
	logic [3:0]        posIdx;
	spm_pkg::spm_mode_t mode;

	always_comb begin
		next_state = state;
		// Only the second stage is read; the first is metastability guard
		next_state.sync1 = pins;
		next_state.sync2 = state.sync1;
		next_state.stepPrev = state.sync2.pulseStep;
		next_state.cyclePrev = state.sync2.powerCycle;
		stepRise = state.sync2.pulseStep & ~state.stepPrev;
		cycleRise = state.sync2.powerCycle & ~state.cyclePrev;

		access = psel & penable & state.pready;
		idx = paddr[5:2];
		hitActive = (paddr & spm_pkg::ADDR_BLOCK_MASK) == spm_pkg::ADDR_ACTIVE_BASE;
		hitPending = (paddr & spm_pkg::ADDR_BLOCK_MASK) == spm_pkg::ADDR_PENDING_BASE;
		expansionOpen = state.active[spm_pkg::IDX_EXPANSION] != spm_pkg::PARAM_RESET;
		lockHit = spm_pkg::LOCKED_MASK[idx] & state.drive.servoActive;
		expHit = spm_pkg::EXPGRP_MASK[idx] & ~expansionOpen;

		// One-cycle access phase: ready rises in the cycle after setup
		next_state.pready = psel & ~penable;
		next_state.pslverr = 1'b0;
		next_state.prdata = 32'h0000_0000;
		if (psel & ~penable) begin
			if (paddr == spm_pkg::ADDR_STATUS) begin
				next_state.prdata = {26'h000_0000, expansionOpen, state.drive.cmdSource,
					state.drive.activeMode, state.drive.servoActive};
			end else if (paddr == spm_pkg::ADDR_REJECT) begin
				next_state.prdata = {30'h0000_0000, state.reject};
			end else if (hitActive) begin
				next_state.prdata = {16'h0000, state.active[idx]};
				next_state.pslverr = pwrite & (lockHit | expHit);
			end else if (hitPending) begin
				next_state.prdata = {16'h0000, state.pending[idx]};
				next_state.pslverr = pwrite;
			end else begin
				next_state.pslverr = 1'b1;
			end
		end

		if (access & pwrite) begin
			if (paddr == spm_pkg::ADDR_REJECT) begin
				next_state.reject = state.reject & ~pwdata[1:0];
			end else if (hitActive) begin
				if (lockHit | expHit) begin
					next_state.reject[spm_pkg::REJ_LOCK] = state.reject[spm_pkg::REJ_LOCK] | lockHit;
					next_state.reject[spm_pkg::REJ_EXP] = state.reject[spm_pkg::REJ_EXP] | expHit;
				end else if (spm_pkg::PWRCYC_MASK[idx]) begin
					next_state.pending[idx] = pwdata[15:0];
				end else begin
					next_state.active[idx] = pwdata[15:0];
				end
			end
		end
		// Sticky reject bits: a new refusal wins over a clear in the same cycle
		if (access & pwrite & hitActive) begin
			next_state.reject[spm_pkg::REJ_LOCK] = next_state.reject[spm_pkg::REJ_LOCK] | lockHit;
			next_state.reject[spm_pkg::REJ_EXP] = next_state.reject[spm_pkg::REJ_EXP] | expHit;
		end

		// Soft power cycle: loads from the old pending copy; a write in the same cycle is kept except to the volatile parameter
		if (cycleRise) begin
			for (int i = 0; i < spm_pkg::NPAR; i++) begin
				if (spm_pkg::PWRCYC_MASK[i]) begin
					next_state.active[i] = state.pending[i];
				end
				if (spm_pkg::VOLATILE_MASK[i]) begin
					next_state.active[i] = spm_pkg::PARAM_RESET;
				end
			end
		end

		next_state.drive.servoActive = state.sync2.servoOnInput
			& (state.active[spm_pkg::IDX_FORCE_OFF] != spm_pkg::FORCE_OFF_ON);

		modeCode = state.active[spm_pkg::IDX_MODE][3:0];
		case (modeCode)
			spm_pkg::MC_PT: begin
				mode = spm_pkg::BM_PT;
			end
			spm_pkg::MC_PR: begin
				mode = spm_pkg::BM_PR;
			end
			spm_pkg::MC_SPEED: begin
				mode = spm_pkg::BM_SPEED;
			end
			spm_pkg::MC_TORQ: begin
				mode = spm_pkg::BM_TORQUE;
			end
			spm_pkg::MC_PT_S: begin
				if (state.sync2.modeToggleInput) begin
					mode = spm_pkg::BM_SPEED;
				end else begin
					mode = spm_pkg::BM_PT;
				end
			end
			spm_pkg::MC_PT_T: begin
				if (state.sync2.modeToggleInput) begin
					mode = spm_pkg::BM_TORQUE;
				end else begin
					mode = spm_pkg::BM_PT;
				end
			end
			spm_pkg::MC_PR_S: begin
				if (state.sync2.modeToggleInput) begin
					mode = spm_pkg::BM_SPEED;
				end else begin
					mode = spm_pkg::BM_PR;
				end
			end
			spm_pkg::MC_PR_T: begin
				if (state.sync2.modeToggleInput) begin
					mode = spm_pkg::BM_TORQUE;
				end else begin
					mode = spm_pkg::BM_PR;
				end
			end
			spm_pkg::MC_S_T: begin
				if (state.sync2.modeToggleInput) begin
					mode = spm_pkg::BM_TORQUE;
				end else begin
					mode = spm_pkg::BM_SPEED;
				end
			end
			default: begin
				// Unknown codes fall back to pulse-train position, the power-up default
				mode = spm_pkg::BM_PT;
			end
		endcase
		next_state.drive.activeMode = mode;

		if (stepRise & state.drive.servoActive & (mode == spm_pkg::BM_PT)) begin
			if (state.sync2.pulseDir) begin
				next_state.drive.goalPosition = state.drive.goalPosition - 16'h0001;
			end else begin
				next_state.drive.goalPosition = state.drive.goalPosition + 16'h0001;
			end
		end

		speedCode = {state.sync2.speedSelectHigh, state.sync2.speedSelectLow};
		speedIdx = spm_pkg::IDX_SPEED1 + {2'b00, speedCode} - 4'h1;
		posIdx = spm_pkg::IDX_POS0 + {1'b0, state.sync2.positionSelect};
		case (mode)
			spm_pkg::BM_PT: begin
				next_state.drive.cmdSource = spm_pkg::SRC_PULSE;
				next_state.drive.cmdValue = next_state.drive.goalPosition;
			end
			spm_pkg::BM_PR: begin
				next_state.drive.cmdSource = spm_pkg::SRC_INTPOS;
				next_state.drive.cmdValue = state.active[posIdx];
			end
			spm_pkg::BM_SPEED: begin
				if (speedCode == 2'b00) begin
					next_state.drive.cmdSource = spm_pkg::SRC_ANALOG;
					next_state.drive.cmdValue = spm_pkg::ANALOG_VALUE;
				end else begin
					next_state.drive.cmdSource = spm_pkg::SRC_SPEEDREG;
					next_state.drive.cmdValue = state.active[speedIdx];
				end
			end
			default: begin
				next_state.drive.cmdSource = spm_pkg::SRC_ANALOG;
				next_state.drive.cmdValue = spm_pkg::ANALOG_VALUE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pready = state.pready;
	assign prdata = state.prdata;
	assign pslverr = state.pslverr;
	assign drive = state.drive;
endmodule
`default_nettype wire

/* verification/spm_store_props.sv */
// Port checks for the parameter store and mode selector
`timescale 1ns/100ps
`default_nettype none
module spm_store_props (
	input wire logic                    clk_sys,
	input wire logic                    resetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [spm_pkg::AW-1:0]  paddr,
	input wire logic [31:0]             pwdata,
	input wire logic                    pready,
	input wire logic [31:0]             prdata,
	input wire logic                    pslverr,
	input wire spm_pkg::spm_pins_t      pins,
	input wire spm_pkg::spm_drive_t     drive
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Pulses spaced by the controller, so one step per rise
	sequence upPulse; $rose(pins.pulseStep) ##0 !pins.pulseDir; endsequence
	sequence ptRun; (drive.servoActive && drive.activeMode == spm_pkg::BM_PT) [*4]; endsequence
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	servo_follow_a: assert property (drive.servoActive |-> $past(pins.servoOnInput, 3))
		else $error("servo active without input");
	lock_refuse_a: assert property (pready && pwrite && paddr == 12'h04C && drive.servoActive
		&& $past(drive.servoActive) |-> pslverr) else $error("locked write taken");
	pulse_count_a: assert property (upPulse ##0 ptRun |-> drive.goalPosition ==
		16'($past(drive.goalPosition) + 16'h0001)) else $error("pulse not counted");
	pulse_source_a: assert property (drive.activeMode == spm_pkg::BM_PT |->
		drive.cmdSource == spm_pkg::SRC_PULSE) else $error("pulse mode source");
	reg_source_a: assert property (drive.activeMode == spm_pkg::BM_PR |->
		drive.cmdSource == spm_pkg::SRC_INTPOS) else $error("register mode source");
	speed_select_a: assert property (drive.activeMode == spm_pkg::BM_SPEED |-> ((drive.cmdSource ==
		spm_pkg::SRC_ANALOG) == !($past(pins.speedSelectHigh, 3) || $past(pins.speedSelectLow, 3))))
		else $error("speed source select");
	torque_analog_a: assert property (drive.activeMode == spm_pkg::BM_TORQUE |->
		drive.cmdSource == spm_pkg::SRC_ANALOG && drive.cmdValue == 16'h0000) else $error("torque source");
endmodule
bind spm_store spm_store_props i_props (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.pins(pins), .drive(drive));
`default_nettype wire

/* verification/spm_ctrl_model.sv */
// Motion controller model driving the digital inputs
`timescale 1ns/100ps
`default_nettype none
module spm_ctrl_model (
	input  wire logic               clk_sys,
	input  wire spm_pkg::spm_pins_t req,
	input  wire logic               pulseGo,
	output var spm_pkg::spm_pins_t  pins,
	output var int                  pulseNet
);
	logic [2:0] phase = 3'h0;
	spm_pkg::spm_pins_t nxtPins;
	initial pins = '0;
	initial pulseNet = 0;
	always @(posedge clk_sys) begin
		nxtPins = req;
		// eight-cycle pulse train, a burst always ends whole
		nxtPins.pulseStep = phase[2];
		pins <= nxtPins;
		if (pulseGo || phase != 3'h0)
			phase <= phase + 3'h1;
		if (phase == 3'h3)
			pulseNet <= pulseNet + (req.pulseDir ? -1 : 1);
	end
endmodule
`default_nettype wire

/* verification/tb_spm_store.sv */
// Self-checking bench for the parameter store and mode selector
`timescale 1ns/100ps
`default_nettype none
module tb_spm_store;
	logic                clk_sys = 1'b0;
	logic                resetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = 12'h000;
	logic [31:0]         pwdata = 32'h0000_0000;
	logic                pready;
	logic [31:0]         prdata;
	logic                pslverr;
	logic                pulseGo = 1'b0;
	int                  pulseNet;
	spm_pkg::spm_pins_t  req = '0;
	spm_pkg::spm_pins_t  pins;
	spm_pkg::spm_drive_t drive;
	int                  error_cnt = 0;
	int                  cmp_count = 0;
	int                  seed = 71;
	logic                servo_on_input = 1'b0;
	logic [15:0]         act [16] = '{default: 16'h0000};
	logic [15:0]         pend [16] = '{default: 16'h0000};
	logic [31:0]         rd;
	logic                err;
	int                  fm [9] = '{0, 1, 2, 3, 0, 0, 1, 1, 2};
	int                  sm [9] = '{0, 1, 2, 3, 2, 3, 2, 3, 3};
	initial forever #12.5 clk_sys = ~clk_sys;
	spm_store i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pins(pins),
		.drive(drive));
	spm_ctrl_model i_ctrl (.clk_sys(clk_sys), .req(req), .pulseGo(pulseGo), .pins(pins), .pulseNet(pulseNet));
	task summarize;
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task pw(input int i, input logic [15:0] v);
		logic bad;
		bad = (spm_pkg::LOCKED_MASK[i] && servo_on_input && act[1] != 16'h0001) || (spm_pkg::EXPGRP_MASK[i] && act[0] == 0);
		apb(1'b1, spm_pkg::ADDR_ACTIVE_BASE + 12'(4 * i), {16'h0000, v});
		chk("write error", 32'(bad), 32'(err));
		if (!bad && spm_pkg::PWRCYC_MASK[i])
			pend[i] = v;
		else if (!bad)
			act[i] = v;
	endtask
	task pr(input int i, input logic [15:0] v);
		apb(1'b0, spm_pkg::ADDR_ACTIVE_BASE + 12'(4 * i), 32'h0000_0000);
		chk("parameter", {16'h0000, v}, rd);
	endtask
	task pcyc;
		req.powerCycle <= 1'b1;
		repeat (4) @(posedge clk_sys);
		req.powerCycle <= 1'b0;
		repeat (4) @(posedge clk_sys);
		act[0] = pend[0];
		act[2] = pend[2];
		act[4] = 16'h0000;
	endtask
	task mchk(input int c);
		int m;
		int s;
		int es;
		logic [15:0] ev;
		m = req.modeToggleInput ? sm[c] : fm[c];
		s = {req.speedSelectHigh, req.speedSelectLow};
		es = m == 0 ? 0 : m == 1 ? 1 : (m == 2 && s != 0) ? 3 : 2;
		ev = m == 1 ? act[8 + req.positionSelect] : (m == 2 && s != 0) ? act[4 + s] : 16'h0000;
		chk("mode", 32'(m), 32'(drive.activeMode));
		chk("source", 32'(es), 32'(drive.cmdSource));
		if (m != 0)
			chk("command", 32'(ev), 32'(drive.cmdValue));
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		pw(5, 16'h1234);
		pw(0, 16'h0001);
		pr(0, 16'h0000);
		apb(1'b0, spm_pkg::ADDR_PENDING_BASE, 32'h0000_0000);
		chk("pending copy", 32'h0000_0001, rd);
		pcyc();
		pr(0, 16'h0001);
		pw(4, 16'h00A5);
		pcyc();
		pr(4, 16'h0000);
		for (int i = 5; i < 16; i++)
			pw(i, 16'($random(seed)));
		req.servoOnInput <= 1'b1;
		servo_on_input = 1'b1;
		repeat (5) @(posedge clk_sys);
		apb(1'b0, spm_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("servo on", 32'h0000_0001, rd & 32'h0000_0001);
		pw(3, 16'h0055);
		apb(1'b0, spm_pkg::ADDR_REJECT, 32'h0000_0000);
		chk("reject flags", 32'h0000_0003, rd);
		apb(1'b1, spm_pkg::ADDR_REJECT, 32'h0000_0003);
		apb(1'b0, spm_pkg::ADDR_REJECT, 32'h0000_0000);
		chk("reject cleared", 32'h0000_0000, rd);
		pw(1, spm_pkg::FORCE_OFF_ON);
		repeat (5) @(posedge clk_sys);
		apb(1'b0, spm_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("servo active", 32'h0000_0000, rd & 32'h0000_0001);
		pw(3, 16'h0055);
		// Operator clears the forced-off setting
		pw(1, 16'h0000);
		for (int c = 0; c < 9; c++) begin
			pw(2, 16'(c));
			pcyc();
			repeat (3) begin
				req.modeToggleInput <= 1'($random(seed));
				req.speedSelectLow <= 1'($random(seed));
				req.speedSelectHigh <= 1'($random(seed));
				req.positionSelect <= 3'($random(seed));
				repeat (5) @(posedge clk_sys);
				mchk(c);
			end
		end
		pw(2, 16'h0000);
		pcyc();
		for (int d = 0; d < 2; d++) begin
			req.pulseDir <= 1'(d);
			pulseGo <= 1'b1;
			repeat (40 - 16 * d) @(posedge clk_sys);
			pulseGo <= 1'b0;
			repeat (20) @(posedge clk_sys);
			chk("goal", 32'(16'(pulseNet)), 32'(drive.goalPosition));
		end
		req.servoOnInput <= 1'b0;
		servo_on_input = 1'b0;
		repeat (5) @(posedge clk_sys);
		apb(1'b0, spm_pkg::ADDR_STATUS, 32'h0000_0000);
		chk("servo released", 32'h0000_0000, rd & 32'h0000_0001);
		pw(3, 16'h00AA);
		pr(3, 16'h00AA);
		summarize();
	end
endmodule
`default_nettype wire
